// *** pkg/asa_consts.svh ***
// constants for the alarm sticky aggregation block
`ifndef ASA_CONSTS_SVH
`define ASA_CONSTS_SVH

`define ASA_NUM_REFS 4
`define ASA_NUM_LOOPS 5
`define ASA_NUM_GPIO 8
`define ASA_REF_ALARMS 3
`define ASA_LOOP_ALARMS 2
`define ASA_NUM_ALARMS 22
`define ASA_NUM_BLOCKS 9
`define ASA_STATE_W 3
`define ASA_SEL_W 5
`define ASA_ALERT_HOLD_NS 200000
`define ASA_CLK_NS 10
`define ASA_ALERT_HOLD_CYC (`ASA_ALERT_HOLD_NS / `ASA_CLK_NS)
`define ASA_LOOP_HOLDOVER 3'h4
`define ASA_LOOP_LOCKED 3'h3

`endif

// *** pkg/asa_pkg.sv ***
// types for the alarm sticky aggregation block
`include "asa_consts.svh"
package asa_pkg;
    typedef logic [`ASA_NUM_ALARMS-1:0] asa_alarms_t;
    typedef logic [`ASA_NUM_BLOCKS-1:0] asa_blocks_t;
    typedef logic [`ASA_NUM_LOOPS-1:0][`ASA_STATE_W-1:0] asa_loop_state_t;
    typedef enum logic [1:0] {
        ASA_GPIO_OFF,
        ASA_GPIO_LIVE,
        ASA_GPIO_STICKY,
        ASA_GPIO_ALERT
    } asa_gpio_mode_t;
    typedef logic [`ASA_NUM_GPIO-1:0][`ASA_SEL_W-1:0] asa_gpio_sel_t;
    typedef asa_gpio_mode_t [`ASA_NUM_GPIO-1:0] asa_gpio_modes_t;
endpackage : asa_pkg

// *** pkg/asa_gpio_if.sv ***
// alarm state passed from the core to the gpio mapper
`timescale 1ns/1ps
interface asa_gpio_if;
    import asa_pkg::*;
    asa_alarms_t live;
    asa_alarms_t sticky;
    logic alert;
    modport core (output live, output sticky, output alert);
    modport mapper (input live, input sticky, input alert);
endinterface : asa_gpio_if

// *** hdl/asa_gpio_map.sv ***
// per-gpio alarm selection and polarity
`timescale 1ns/1ps
`include "asa_consts.svh"
module asa_gpio_map (
    input wire logic i_clk,
    input wire logic i_rst_n,
    asa_gpio_if.mapper src,
    input asa_pkg::asa_gpio_modes_t i_mode,
    input asa_pkg::asa_gpio_sel_t i_sel,
    input wire logic [`ASA_NUM_GPIO-1:0] i_invert,
    output logic [`ASA_NUM_GPIO-1:0] o_gpio,
    output logic [`ASA_NUM_GPIO-1:0] o_gpio_oe
);
    import asa_pkg::*;

    typedef struct packed {
        logic [`ASA_NUM_GPIO-1:0] pin;
        logic [`ASA_NUM_GPIO-1:0] oe;
    } asa_map_state_t;

    asa_map_state_t state;
    asa_map_state_t next_state;

    function automatic logic pick(input asa_alarms_t v, input logic [`ASA_SEL_W-1:0] s);
        pick = (s < `ASA_NUM_ALARMS) ? v[s] : 1'b0;
    endfunction : pick

    always_comb begin
        next_state = state;
        for (int g = 0; g < `ASA_NUM_GPIO; g++) begin
            logic raw;
            raw = 1'b0;
            unique case (i_mode[g])
                ASA_GPIO_OFF: raw = 1'b0;
                ASA_GPIO_LIVE: raw = pick(src.live, i_sel[g]); // R4 R22 R23
                ASA_GPIO_STICKY: raw = pick(src.sticky, i_sel[g]); // R4 R23
                ASA_GPIO_ALERT: raw = src.alert; // R9
            endcase
            // high means present; inversion flips both single and alert pins
            next_state.pin[g] = raw ^ i_invert[g]; // R5 R8
            next_state.oe[g] = (i_mode[g] != ASA_GPIO_OFF);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_gpio = state.pin;
    assign o_gpio_oe = state.oe;
endmodule : asa_gpio_map

// *** hdl/asa_alarm_core.sv ***
// alarm live, sticky, block sticky and alert aggregation
// How it works
// R1 - live bit is current alarm, unlatched
// R2 - sticky holds until software clear
// R3 - sticky sets on every live change while global enable is high
// R4 - gpio shows live or sticky alarm
// R5 - per gpio polarity inversion
// R6 - alert uses sticky bits only
// R7 - alert is OR of enabled stickies
// R8 - alert polarity may be inverted
// R9 - one gpio may carry the alert
// R10 - holdover live while loop in holdover
// R11 - locked live needs loop and apll locked
// R12 - sources: three ref, two loop alarms
// R13 - loop stickies on state transitions
// R14 - live, sticky, clear, enables per alarm
// R15 - clear any combination in one write
// R16 - block stickies hold alert until cleared
// R17 - software clears individual before block stickies
// R18 - alert may lag clears by 200 us
// R19 - global enable gates all sources
// R20 - loop state field readable
// R21 - all status readable as ports
// R22 - los gpio shows live state
// R23 - lock/holdover gpio live or sticky
// R24 - set wins over simultaneous clear
`timescale 1ns/1ps
`include "asa_consts.svh"
module asa_alarm_core (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [`ASA_NUM_REFS-1:0] i_ref_freq_alarm,
    input wire logic [`ASA_NUM_REFS-1:0] i_ref_los_alarm,
    input wire logic [`ASA_NUM_REFS-1:0] i_ref_activity_alarm,
    input asa_pkg::asa_loop_state_t i_loop_state,
    input wire logic i_apll_locked,
    input wire logic i_global_enable,
    input asa_pkg::asa_alarms_t i_sticky_clear,
    input asa_pkg::asa_blocks_t i_block_clear,
    input asa_pkg::asa_alarms_t i_alert_enable,
    input asa_pkg::asa_gpio_modes_t i_gpio_mode,
    input asa_pkg::asa_gpio_sel_t i_gpio_sel,
    input wire logic [`ASA_NUM_GPIO-1:0] i_gpio_invert,
    output asa_pkg::asa_alarms_t o_live,
    output asa_pkg::asa_alarms_t o_sticky,
    output asa_pkg::asa_blocks_t o_block_sticky,
    output asa_pkg::asa_loop_state_t o_loop_state,
    output logic o_alert,
    output logic [`ASA_NUM_GPIO-1:0] o_gpio,
    output logic [`ASA_NUM_GPIO-1:0] o_gpio_oe
);
    import asa_pkg::*;

    localparam int REF_BITS = `ASA_NUM_REFS * `ASA_REF_ALARMS;
    localparam int LOOP_BITS = `ASA_NUM_LOOPS * `ASA_LOOP_ALARMS;

    typedef struct packed {
        logic [`ASA_NUM_REFS-1:0] fr_m;
        logic [`ASA_NUM_REFS-1:0] ls_m;
        logic [`ASA_NUM_REFS-1:0] ac_m;
        logic [`ASA_NUM_REFS-1:0] fr_s;
        logic [`ASA_NUM_REFS-1:0] ls_s;
        logic [`ASA_NUM_REFS-1:0] ac_s;
        logic ap_m;
        logic ap_s;
        logic ap_p;
        asa_loop_state_t st_m;
        asa_loop_state_t st_s;
        asa_loop_state_t st_p;
        asa_loop_state_t st_q;
        asa_alarms_t live;
        asa_alarms_t sticky;
        asa_blocks_t block;
        asa_loop_state_t loop_state;
        logic alert;
        logic [17:0] hold;
    } asa_core_state_t;

    asa_core_state_t state;
    asa_core_state_t next_state;
    asa_alarms_t cur_live;
    asa_alarms_t changed;
    asa_blocks_t hits;

    asa_gpio_if link();

    // slot layout: ref r owns 3r..3r+2, loop l owns 12+2l (holdover) and 13+2l (locked)
    function automatic int ref_slot(input int r, input int k);
        ref_slot = `ASA_REF_ALARMS * r + k;
    endfunction : ref_slot

    function automatic int hold_slot(input int l);
        hold_slot = REF_BITS + `ASA_LOOP_ALARMS * l;
    endfunction : hold_slot

    function automatic int lock_slot(input int l);
        lock_slot = hold_slot(l) + 1;
    endfunction : lock_slot

    function automatic asa_blocks_t block_of(input int a);
        block_of = '0;
        if (a < REF_BITS) begin
            block_of[a / `ASA_REF_ALARMS] = 1'b1;
        end else if (a < REF_BITS + LOOP_BITS) begin
            block_of[`ASA_NUM_REFS + (a - REF_BITS) / `ASA_LOOP_ALARMS] = 1'b1;
        end
    endfunction : block_of

    function automatic asa_alarms_t ref_live(
        input logic [`ASA_NUM_REFS-1:0] freq,
        input logic [`ASA_NUM_REFS-1:0] los,
        input logic [`ASA_NUM_REFS-1:0] act
    );
        ref_live = '0;
        for (int r = 0; r < `ASA_NUM_REFS; r++) begin
            ref_live[ref_slot(r, 0)] = freq[r];
            ref_live[ref_slot(r, 1)] = los[r];
            ref_live[ref_slot(r, 2)] = act[r];
        end
    endfunction : ref_live

    // a loop counts as locked only while the system apll is locked too
    function automatic asa_alarms_t loop_live(input asa_loop_state_t st, input logic apll);
        loop_live = '0;
        for (int l = 0; l < `ASA_NUM_LOOPS; l++) begin
            loop_live[hold_slot(l)] = (st[l] == `ASA_LOOP_HOLDOVER);
            loop_live[lock_slot(l)] = (st[l] == `ASA_LOOP_LOCKED) && apll;
        end
    endfunction : loop_live

    // a state word is taken only after two equal synchronised samples, so a code
    // caught mid-change is never decoded; costs two cycles of latency
    function automatic asa_loop_state_t settle(
        input asa_loop_state_t held,
        input asa_loop_state_t now,
        input asa_loop_state_t prev
    );
        settle = held;
        for (int l = 0; l < `ASA_NUM_LOOPS; l++) begin
            if (now[l] == prev[l]) begin
                settle[l] = now[l];
            end
        end
    endfunction : settle

    // only alarms enabled toward the alert may raise a block sticky
    function automatic asa_blocks_t raise_blocks(input asa_alarms_t hit, input asa_alarms_t en);
        raise_blocks = '0;
        for (int a = 0; a < `ASA_NUM_ALARMS; a++) begin
            if (hit[a] && en[a]) begin
                raise_blocks = raise_blocks | block_of(a);
            end
        end
    endfunction : raise_blocks

    function automatic logic [17:0] next_hold(input logic feed, input logic [17:0] hold);
        if (feed) begin
            next_hold = 18'(`ASA_ALERT_HOLD_CYC);
        end else if (hold != 18'h0) begin
            next_hold = hold - 18'h1;
        end else begin
            next_hold = 18'h0;
        end
    endfunction : next_hold

    always_comb begin
        cur_live = ref_live(state.fr_s, state.ls_s, state.ac_s); // R12
        cur_live = cur_live | loop_live(state.st_q, state.ap_p); // R10 R11 R13
    end

    always_comb begin
        logic feed;
        feed = 1'b0;
        next_state = state;

        // two-flop synchronisers on the monitor and loop status levels
        next_state.fr_m = i_ref_freq_alarm;
        next_state.ls_m = i_ref_los_alarm;
        next_state.ac_m = i_ref_activity_alarm;
        next_state.ap_m = i_apll_locked;
        next_state.st_m = i_loop_state;
        next_state.fr_s = state.fr_m;
        next_state.ls_s = state.ls_m;
        next_state.ac_s = state.ac_m;
        next_state.ap_s = state.ap_m;
        next_state.st_s = state.st_m;

        // settle stage for the state words; the apll level is delayed one cycle here, one cycle less than the settled state words
        next_state.st_p = state.st_s;
        next_state.st_q = settle(state.st_q, state.st_s, state.st_p);
        next_state.ap_p = state.ap_s;

        next_state.live = cur_live; // R1
        next_state.loop_state = state.st_q; // R20

        // global enable masks new events only; held stickies stay readable
        changed = (cur_live ^ state.live) & {`ASA_NUM_ALARMS{i_global_enable}}; // R19 R3
        // set wins over clear so an event on the clear cycle is kept
        next_state.sticky = (state.sticky & ~i_sticky_clear) | changed; // R2 R15 R24

        // a still-set individual sticky re-raises its block bit, so clear those first
        hits = raise_blocks(changed | state.sticky, i_alert_enable); // R7
        next_state.block = (state.block & ~i_block_clear) | hits; // R16 R17 R24

        // alert only from enabled stickies plus block stickies
        feed = |(state.sticky & i_alert_enable) || |state.block; // R6 R7 R16
        // release lags the last clear by the hold count, within the allowed window
        next_state.hold = next_hold(feed, state.hold); // R18
        next_state.alert = feed || (state.hold > 18'h1); // R18
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.live = state.live;
    assign link.sticky = state.sticky;
    assign link.alert = state.alert;

    asa_gpio_map u_map (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .src(link.mapper),
        .i_mode(i_gpio_mode),
        .i_sel(i_gpio_sel),
        .i_invert(i_gpio_invert),
        .o_gpio(o_gpio),
        .o_gpio_oe(o_gpio_oe)
    );

    assign o_live = state.live; // R1 R14 R21
    assign o_sticky = state.sticky; // R14 R21
    assign o_block_sticky = state.block;
    assign o_loop_state = state.loop_state; // R20
    assign o_alert = state.alert;
endmodule : asa_alarm_core

// *** test/asa_alarm_checker.sv ***
// assertions on the alarm core ports
`timescale 1ns/1ps
`include "asa_consts.svh"
module asa_alarm_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input asa_pkg::asa_loop_state_t i_loop_state,
    input wire logic i_apll_locked,
    input wire logic i_global_enable,
    input asa_pkg::asa_alarms_t i_sticky_clear,
    input asa_pkg::asa_alarms_t i_alert_enable,
    input asa_pkg::asa_gpio_modes_t i_gpio_mode,
    input asa_pkg::asa_gpio_sel_t i_gpio_sel,
    input wire logic [`ASA_NUM_GPIO-1:0] i_gpio_invert,
    input asa_pkg::asa_alarms_t o_live,
    input asa_pkg::asa_alarms_t o_sticky,
    input asa_pkg::asa_blocks_t o_block_sticky,
    input logic o_alert,
    input logic [`ASA_NUM_GPIO-1:0] o_gpio
);
    import asa_pkg::*;
    localparam int HOLD = `ASA_ALERT_HOLD_CYC;
    logic [15:0] quiet;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // saturates so a long idle run cannot wrap back into the window
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) quiet <= '0;
        else if ((o_sticky & i_alert_enable) != '0 || o_block_sticky != '0) quiet <= '0;
        else if (quiet != 16'hffff) quiet <= quiet + 16'h1;
    end
    AST_HOLD: assert property (1 |=> (o_sticky | ~$past(o_sticky & ~i_sticky_clear)) == '1)
        else $error("sticky bit dropped without clear");
    AST_CHG: assert property (
        (i_global_enable && $past(i_global_enable) && $past(i_global_enable, 2)
        && $past(i_global_enable, 3)) |-> (o_sticky | ~(o_live ^ $past(o_live))) == '1)
        else $error("live change did not set sticky");
    AST_ALERT_SET: assert property (((o_sticky & i_alert_enable) != '0) |=> o_alert)
        else $error("enabled sticky did not raise alert");
    AST_ALERT_DROP: assert property ($fell(o_alert) |-> quiet > HOLD - 4 && quiet < HOLD + 4)
        else $error("alert dropped at wrong time");
    AST_ALERT_LOW: assert property (quiet == HOLD + 4 |-> !o_alert)
        else $error("alert held too long");
    AST_HOLDOVER: assert property (
        ($past(i_rst_n, 5) && $past(i_loop_state[0], 4) == $past(i_loop_state[0], 5))
        |-> o_live[12] == ($past(i_loop_state[0], 4) == `ASA_LOOP_HOLDOVER))
        else $error("holdover live wrong");
    AST_LOCKED: assert property (
        ($past(i_rst_n, 5) && $past(i_loop_state[0], 4) == $past(i_loop_state[0], 5))
        |-> o_live[13] == ($past(i_loop_state[0], 4) == `ASA_LOOP_LOCKED
        && $past(i_apll_locked, 4)))
        else $error("locked live wrong");
    AST_GPIO_ALERT: assert property (
        (i_gpio_mode[0] == ASA_GPIO_ALERT && $past(i_rst_n, 2)
        && $stable(i_gpio_mode) && $stable(i_gpio_invert))
        |=> o_gpio[0] == ($past(o_alert) ^ $past(i_gpio_invert[0])))
        else $error("alert gpio wrong");
    AST_GPIO_LIVE: assert property (
        (i_gpio_mode[1] == ASA_GPIO_LIVE && $past(i_rst_n, 2)
        && $stable(i_gpio_sel) && $stable(i_gpio_invert))
        |=> o_gpio[1] == ($past(o_live[i_gpio_sel[1]]) ^ $past(i_gpio_invert[1])))
        else $error("live gpio wrong");
endmodule : asa_alarm_checker
bind asa_alarm_core asa_alarm_checker chk_i (.i_clk, .i_rst_n, .i_loop_state, .i_apll_locked,
    .i_global_enable, .i_sticky_clear, .i_alert_enable, .i_gpio_mode, .i_gpio_sel,
    .i_gpio_invert, .o_live, .o_sticky, .o_block_sticky, .o_alert, .o_gpio);

// *** test/asa_host_model.sv ***
// host side model: software clearing stickies
`timescale 1ns/1ps
module asa_host_model (
    input wire logic i_clk,
    output asa_pkg::asa_alarms_t o_sticky_clear,
    output asa_pkg::asa_blocks_t o_block_clear
);
    import asa_pkg::*;
    initial begin
        o_sticky_clear = '0;
        o_block_clear = '0;
    end
    // individual bits first, else they would set the block bit again
    task clear(input asa_alarms_t a, input asa_blocks_t b);
        @(negedge i_clk);
        o_sticky_clear <= a;
        @(negedge i_clk);
        o_sticky_clear <= '0;
        o_block_clear <= b;
        @(negedge i_clk);
        o_block_clear <= '0;
    endtask : clear
endmodule : asa_host_model

// *** test/tb.sv ***
// self-checking bench for the alarm core
`timescale 1ns/1ps
module tb;
    import asa_pkg::*;
    logic i_clk, i_rst_n, apll, gen, alert;
    logic [3:0] f_al, l_al, a_al;
    logic [7:0] inv, gpio, oe;
    asa_loop_state_t st, o_st;
    asa_alarms_t sclr, aen, live, stk;
    asa_blocks_t bclr, blk;
    asa_gpio_modes_t mode;
    asa_gpio_sel_t sel;
    int miscompares, checks;
    asa_alarm_core uut (.i_clk, .i_rst_n, .i_ref_freq_alarm(f_al), .i_ref_los_alarm(l_al),
        .i_ref_activity_alarm(a_al), .i_loop_state(st), .i_apll_locked(apll),
        .i_global_enable(gen), .i_sticky_clear(sclr), .i_block_clear(bclr),
        .i_alert_enable(aen), .i_gpio_mode(mode), .i_gpio_sel(sel), .i_gpio_invert(inv),
        .o_live(live), .o_sticky(stk), .o_block_sticky(blk), .o_loop_state(o_st),
        .o_alert(alert), .o_gpio(gpio), .o_gpio_oe(oe));
    asa_host_model host (.i_clk, .o_sticky_clear(sclr), .o_block_clear(bclr));
    task tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    task chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task end_of_test;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // whole run is about 20200 cycles
    initial begin
        #400us;
        miscompares++;
        end_of_test();
    end
    initial begin
        i_rst_n = 1'b0;
        {f_al, l_al, a_al, apll} = '0;
        st = '0;
        gen = 1'b1;
        aen = '1;
        for (int k = 0; k < 8; k++) mode[k] = ASA_GPIO_OFF;
        mode[0] = ASA_GPIO_ALERT;
        mode[1] = ASA_GPIO_LIVE;
        mode[2] = ASA_GPIO_STICKY;
        sel = '0;
        sel[1] = 5'h01;
        sel[2] = 5'h0c;
        inv = 8'h05;
        tick(5);
        i_rst_n = 1'b1;
        tick(2);
        chk({alert, blk, stk}, '0);
        st[0] = 3'h4;
        tick(6);
        chk({live[12], stk[12], blk[4]}, 3'h7);
        st[0] = 3'h3;
        tick(6);
        chk(live[13:12], 2'h0);
        apll = 1'b1;
        tick(6);
        chk(live[13:12], 2'h2);
        st[4] = 3'h4;
        tick(6);
        chk({live[20], blk[8], o_st}, {2'h3, st});
        gen = 1'b0;
        tick(4);
        f_al[1] = 1'b1;
        a_al[3] = 1'b1;
        tick(6);
        chk({live[3], stk[3], live[11], stk[11]}, 4'ha);
        gen = 1'b1;
        tick(4);
        host.clear('1, '1);
        tick(3);
        chk({alert, blk, stk}, {1'b1, 31'h0});
        tick(100);
        chk(alert, 1'b1);
        tick(20000);
        chk(alert, 1'b0);
        l_al[0] = 1'b1;
        tick(6);
        chk({live[1], stk[1], blk[0]}, 3'h7);
        chk({oe, gpio}, 16'h0706);
        host.clear(22'h2, 9'h0);
        tick(3);
        chk({stk[1], blk[0], alert}, 3'h3);
        l_al[0] = 1'b0;
        tick(1);
        host.clear(22'h2, 9'h0);
        tick(20);
        chk({live[1], stk[1]}, 2'h1);
        end_of_test();
    end
endmodule : tb
